// ==== core/psc_regs.vh ====
// Function
// - Held input with pull-up: float, pull-up stays on
// - Held output keeps driving its previous level
// - Address pins in sleep hold last address
// - Software standby resets peripherals; pins become GPIO
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// Register byte offsets
`define PSC_SYSC_OFS       8'h00
`define PSC_CMD_OFS        8'h04
`define PSC_DDR_OFS        8'h08
`define PSC_DAT_OFS        8'h0c
`define PSC_PU_OFS         8'h10
`define PSC_OWN_OFS        8'h14
`define PSC_STAT_OFS       8'h18

// System control fields
`define PSC_RAMEN_BIT      0
`define PSC_MODE_LSB       1
`define PSC_MODE_MSB       2
`define PSC_CKDIR_BIT      3
`define PSC_SYSC_W         4
`define PSC_SYSC_RST       4'h7
`define PSC_MODE_SINGLE    2'h3

// Command fields
`define PSC_CMD_SLEEP_BIT  0
`define PSC_CMD_SWSTBY_BIT 1

// Status fields
`define PSC_STAT_ST_LSB    0
`define PSC_STAT_ST_MSB    2
`define PSC_STAT_RAM_BIT   4
`define PSC_STAT_EXIT_BIT  5
`define PSC_STAT_PIN_LSB   8
`define PSC_STAT_PIN_MSB   23

// Processing states
`define PSC_ST_W           3
`define PSC_ST_NORMAL      3'h0
`define PSC_ST_SLEEP       3'h1
`define PSC_ST_SWSTBY      3'h2
`define PSC_ST_RESET       3'h3
`define PSC_ST_HWSTBY      3'h4

// Pin counts
`define PSC_NPIN           16
`define PSC_NGEN           8

// Timing
`define PSC_CLK_NS         10
`define PSC_ENTRY_LEAD_CYC 10
`define PSC_EXIT_LEAD_NS   100
`define PSC_EXIT_LEAD_CYC  ((`PSC_EXIT_LEAD_NS+`PSC_CLK_NS-1)/`PSC_CLK_NS)
`define PSC_CNT_W          8
`define PSC_CNT_MAX        8'hff

// Bus answers
`define PSC_RESP_OKAY      2'h0
`define PSC_RESP_SLVERR    2'h2

`endif

// ==== core/psc_pin_cell.v ====
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

// One port pin: picks driver and pull-up per processing state
module psc_pin_cell (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [`PSC_ST_W-1:0] st,
	input  wire                 ddr,
	input  wire                 dat,
	input  wire                 pu_req,
	input  wire                 own,
	input  wire                 pout,
	input  wire                 poe,
	output reg                  pin_out,
	output reg                  pin_oe_n,
	output reg                  pin_pu
);

	// Pin state register
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out  <= 1'b0;
			pin_oe_n <= 1'b1;
			pin_pu   <= 1'b0;
		end else begin
			case (st)
				// Reset and hardware standby float the pin
				`PSC_ST_RESET, `PSC_ST_HWSTBY: begin
					pin_out  <= 1'b0;
					pin_oe_n <= 1'b1;
					pin_pu   <= 1'b0;
				end
				// Sleep freezes the driver; pull-up only if floating
				`PSC_ST_SLEEP: begin
					pin_pu <= pin_oe_n & pu_req;
				end
				// Peripheral gone: plain port from direction/data
				`PSC_ST_SWSTBY: begin
					pin_out  <= dat;
					pin_oe_n <= ~ddr;
					pin_pu   <= ~ddr & pu_req;
				end
				// Normal run: peripheral or general port
				default: begin
					if (own) begin
						pin_out  <= pout;
						pin_oe_n <= ~poe;
						pin_pu   <= 1'b0;
					end else begin
						pin_out  <= dat;
						pin_oe_n <= ~ddr;
						pin_pu   <= ~ddr & pu_req;
					end
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== core/psc_axil.v ====
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

// AXI4-Lite slave front end; one write and one read in flight
module psc_axil (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	output reg         wr_pulse,
	output reg  [7:0]  wr_addr,
	output reg  [31:0] wr_data,
	output reg  [3:0]  wr_strb,
	input  wire        wr_hit,
	output reg  [7:0]  rd_addr,
	input  wire [31:0] rd_data,
	input  wire        rd_hit
);

	reg aw_full;  // Address captured
	reg w_full;   // Data captured
	reg rd_pend;  // Read address captured, data next

	// Write path: address and data in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			aw_full  <= 1'b0;
			w_full   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= `PSC_RESP_OKAY;
			wr_pulse <= 1'b0;
			wr_addr  <= 8'h00;
			wr_data  <= 32'h0000_0000;
			wr_strb  <= 4'h0;
		end else begin
			wr_pulse <= 1'b0;
			if (awvalid && awready) begin
				wr_addr <= awaddr;
				aw_full <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
				w_full  <= 1'b1;
				wready  <= 1'b0;
			end
			// Both halves present: commit and answer
			if (aw_full && w_full && !bvalid) begin
				wr_pulse <= wr_hit;
				bresp    <= wr_hit ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
				bvalid   <= 1'b1;
				aw_full  <= 1'b0;
				w_full   <= 1'b0;
			end
			// Reopen only after the response is taken
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read path: data one cycle after the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `PSC_RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				rd_addr <= araddr;
				rd_pend <= 1'b1;
				arready <= 1'b0;
			end
			if (rd_pend) begin
				rdata   <= rd_hit ? rd_data : 32'h0000_0000;
				rresp   <= rd_hit ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
				rvalid  <= 1'b1;
				rd_pend <= 1'b0;
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ==== core/psc_port_ctrl.v ====
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

// Port state and standby controller
module psc_port_ctrl (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [7:0]           awaddr,
	input  wire                 awvalid,
	output wire                 awready,
	input  wire [31:0]          wdata,
	input  wire [3:0]           wstrb,
	input  wire                 wvalid,
	output wire                 wready,
	output wire [1:0]           bresp,
	output wire                 bvalid,
	input  wire                 bready,
	input  wire [7:0]           araddr,
	input  wire                 arvalid,
	output wire                 arready,
	output wire [31:0]          rdata,
	output wire [1:0]           rresp,
	output wire                 rvalid,
	input  wire                 rready,
	input  wire                 reset_n_pin,
	input  wire                 hw_standby_n_pin,
	input  wire                 wake_req,
	input  wire [7:0]           bus_addr,
	input  wire                 bus_addr_valid,
	input  wire                 bus_as_n,
	input  wire                 bus_wr_n,
	input  wire                 bus_rd_n,
	input  wire [`PSC_NGEN-1:0] periph_out,
	input  wire [`PSC_NGEN-1:0] periph_oe,
	input  wire [`PSC_NPIN-1:0] pin_in,
	output wire [`PSC_NPIN-1:0] pin_out,
	output wire [`PSC_NPIN-1:0] pin_oe_n,
	output wire [`PSC_NPIN-1:0] pin_pu,
	output reg  [2:0]           strobe_out,
	output reg  [2:0]           strobe_oe_n,
	output reg                  clk_pin_out,
	output reg                  clk_pin_oe_n,
	output reg                  ram_hold
);

	// Processing states
	localparam ST_NORMAL = `PSC_ST_NORMAL;
	localparam ST_SLEEP  = `PSC_ST_SLEEP;
	localparam ST_SWSTBY = `PSC_ST_SWSTBY;
	localparam ST_RESET  = `PSC_ST_RESET;
	localparam ST_HWSTBY = `PSC_ST_HWSTBY;

	// Lead-time thresholds in clock cycles
	localparam [`PSC_CNT_W-1:0] ENTRY_CYC = `PSC_ENTRY_LEAD_CYC;
	localparam [`PSC_CNT_W-1:0] EXIT_CYC  = `PSC_EXIT_LEAD_CYC;

	// Bus side wires
	wire                 wr_pulse;    // One-cycle register write
	wire [7:0]           wr_addr;     // Write byte address
	wire [31:0]          wr_data;     // Write data
	wire [3:0]           wr_strb;     // Byte lanes
	wire [7:0]           rd_addr;     // Read byte address
	reg  [31:0]          rd_data;     // Read mux
	wire                 wr_hit;      // Write address mapped
	wire                 rd_hit;      // Read address mapped

	// Software-visible state
	reg  [`PSC_SYSC_W-1:0]  system_control_reg; // RAM enable, mode, ck dir
	reg  [`PSC_NPIN-1:0]    pin_dir;            // Direction per pin
	reg  [`PSC_NPIN-1:0]    pin_data_bit;       // Output data per pin
	reg  [`PSC_NPIN-1:0]    pullup_control_bit; // Pull-up request
	reg  [`PSC_NGEN-1:0]    periph_own;         // Peripheral owns pin

	// Processing state machine
	reg  [`PSC_ST_W-1:0]    st;         // Current state
	reg  [`PSC_ST_W-1:0]    next_st;    // Next state

	// Standby sequence monitor
	reg  [`PSC_CNT_W-1:0]   rst_low_cnt; // Cycles reset pin held low
	reg                     hw_standby_n_pin_prev;   // Standby pin last cycle
	reg                     exit_ok;     // Last exit was well ordered

	// Last address driven by the bus
	reg  [7:0]              last_addr;
	reg                     clk_tgl;     // Divided clock for the pin

	// Mode decode
	wire ram_enable_bit = system_control_reg[`PSC_RAMEN_BIT];
	wire expanded = system_control_reg[`PSC_MODE_MSB:`PSC_MODE_LSB]
		!= `PSC_MODE_SINGLE;
	wire clk_dir = system_control_reg[`PSC_CKDIR_BIT];

	// Command decode
	wire cmd_wr = wr_pulse && (wr_addr == `PSC_CMD_OFS) && wr_strb[0];
	wire cmd_sleep  = cmd_wr && wr_data[`PSC_CMD_SLEEP_BIT];
	wire cmd_swstby = cmd_wr && wr_data[`PSC_CMD_SWSTBY_BIT];

	// Mapped-address check, shared by both directions
	function addr_ok;
		input [7:0] a;
		begin
			case (a)
				`PSC_SYSC_OFS, `PSC_CMD_OFS, `PSC_DDR_OFS,
				`PSC_DAT_OFS, `PSC_PU_OFS, `PSC_OWN_OFS,
				`PSC_STAT_OFS: addr_ok = 1'b1;
				default:       addr_ok = 1'b0;
			endcase
		end
	endfunction

	// Byte-lane merge for 16-bit registers
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] d;
		input [3:0]  s;
		begin
			merge16 = {s[1] ? d[15:8] : old[15:8],
				s[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	assign wr_hit = addr_ok(wr_addr);
	assign rd_hit = addr_ok(rd_addr);

	// Bus slave
	psc_axil u_axil (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.awaddr   (awaddr),
		.awvalid  (awvalid),
		.awready  (awready),
		.wdata    (wdata),
		.wstrb    (wstrb),
		.wvalid   (wvalid),
		.wready   (wready),
		.bresp    (bresp),
		.bvalid   (bvalid),
		.bready   (bready),
		.araddr   (araddr),
		.arvalid  (arvalid),
		.arready  (arready),
		.rdata    (rdata),
		.rresp    (rresp),
		.rvalid   (rvalid),
		.rready   (rready),
		.wr_pulse (wr_pulse),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.wr_strb  (wr_strb),
		.wr_hit   (wr_hit),
		.rd_addr  (rd_addr),
		.rd_data  (rd_data),
		.rd_hit   (rd_hit)
	);

	// Read mux
	always @* begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			`PSC_SYSC_OFS:  rd_data[`PSC_SYSC_W-1:0] = system_control_reg;
			`PSC_DDR_OFS:   rd_data[`PSC_NPIN-1:0] = pin_dir;
			`PSC_DAT_OFS:   rd_data[`PSC_NPIN-1:0] = pin_data_bit;
			`PSC_PU_OFS:    rd_data[`PSC_NPIN-1:0] = pullup_control_bit;
			`PSC_OWN_OFS:   rd_data[`PSC_NGEN-1:0] = periph_own;
			`PSC_STAT_OFS: begin
				rd_data[`PSC_STAT_ST_MSB:`PSC_STAT_ST_LSB] = st;
				rd_data[`PSC_STAT_RAM_BIT] = ram_hold;
				rd_data[`PSC_STAT_EXIT_BIT] = exit_ok;
				rd_data[`PSC_STAT_PIN_MSB:`PSC_STAT_PIN_LSB] = pin_in;
			end
			// Command register reads as zero
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// Register writes; peripheral ownership cleared on software standby entry
	always @(posedge aclk) begin
		if (!aresetn) begin
			system_control_reg <= `PSC_SYSC_RST;
			pin_dir            <= 16'h0000;
			pin_data_bit       <= 16'h0000;
			pullup_control_bit <= 16'h0000;
			periph_own         <= 8'h00;
		end else begin
			if (wr_pulse && wr_addr == `PSC_SYSC_OFS && wr_strb[0])
				system_control_reg <= wr_data[`PSC_SYSC_W-1:0];
			if (wr_pulse && wr_addr == `PSC_DDR_OFS)
				pin_dir <= merge16(pin_dir, wr_data, wr_strb);
			if (wr_pulse && wr_addr == `PSC_DAT_OFS)
				pin_data_bit <= merge16(pin_data_bit, wr_data, wr_strb);
			if (wr_pulse && wr_addr == `PSC_PU_OFS)
				pullup_control_bit <=
					merge16(pullup_control_bit, wr_data, wr_strb);
			// Entering software standby re-initialises peripherals
			if (st != ST_SWSTBY && next_st == ST_SWSTBY)
				periph_own <= 8'h00;
			else if (wr_pulse && wr_addr == `PSC_OWN_OFS && wr_strb[0])
				periph_own <= wr_data[`PSC_NGEN-1:0];
		end
	end

	// Next processing state; standby pin outranks reset pin
	always @* begin
		next_st = st;
		if (!hw_standby_n_pin)
			next_st = ST_HWSTBY;
		else if (!reset_n_pin)
			next_st = ST_RESET;
		else begin
			case (st)
				ST_NORMAL: begin
					if (cmd_swstby)
						next_st = ST_SWSTBY;
					else if (cmd_sleep)
						next_st = ST_SLEEP;
				end
				// Any wake event resumes execution
				ST_SLEEP, ST_SWSTBY: begin
					if (wake_req)
						next_st = ST_NORMAL;
				end
				// Pins released: start running
				ST_RESET, ST_HWSTBY: next_st = ST_NORMAL;
				default: next_st = ST_NORMAL;
			endcase
		end
	end

	// State register
	always @(posedge aclk) begin
		if (!aresetn)
			st <= ST_RESET;
		else
			st <= next_st;
	end

	// Standby entry and exit ordering monitor
	always @(posedge aclk) begin
		if (!aresetn) begin
			rst_low_cnt <= 8'h00;
			hw_standby_n_pin_prev   <= 1'b1;
			ram_hold    <= 1'b0;
			exit_ok     <= 1'b0;
		end else begin
			hw_standby_n_pin_prev <= hw_standby_n_pin;
			// Saturating count of reset-low cycles
			if (reset_n_pin)
				rst_low_cnt <= 8'h00;
			else if (rst_low_cnt != `PSC_CNT_MAX)
				rst_low_cnt <= rst_low_cnt + 8'h01;
			// Falling standby: RAM kept only with enough lead
			// Counted cycles precede the fall, so release at the
			// same edge still counts
			if (hw_standby_n_pin_prev && !hw_standby_n_pin)
				ram_hold <= ram_enable_bit &&
					rst_low_cnt >= ENTRY_CYC;
			// Rising standby: was reset held low long enough
			if (!hw_standby_n_pin_prev && hw_standby_n_pin) begin
				exit_ok <= !reset_n_pin &&
					rst_low_cnt >= EXIT_CYC;
				// Bad wake-up order loses the retained contents
				if (reset_n_pin || rst_low_cnt < EXIT_CYC)
					ram_hold <= 1'b0;
			end
		end
	end

	// Address latch and clock divider
	always @(posedge aclk) begin
		if (!aresetn) begin
			last_addr <= 8'h00;
			clk_tgl   <= 1'b0;
		end else begin
			clk_tgl <= ~clk_tgl;
			// Only real accesses update; sleep then holds it
			if (bus_addr_valid && st == ST_NORMAL)
				last_addr <= bus_addr;
		end
	end

	// Pin cells: general port low byte, address port high byte
	genvar gi;
	generate
		for (gi = 0; gi < `PSC_NPIN; gi = gi + 1) begin : g_pin
			wire own_i;
			wire pout_i;
			wire poe_i;
			if (gi < `PSC_NGEN) begin : g_gen
				assign own_i  = periph_own[gi];
				assign pout_i = periph_out[gi];
				assign poe_i  = periph_oe[gi];
			end else begin : g_addr
				// Expanded modes hand the byte to the bus
				assign own_i  = expanded;
				assign pout_i = last_addr[gi-`PSC_NGEN];
				assign poe_i  = 1'b1;
			end
			psc_pin_cell u_cell (
				.aclk     (aclk),
				.aresetn  (aresetn),
				.st       (st),
				.ddr      (pin_dir[gi]),
				.dat      (pin_data_bit[gi]),
				.pu_req   (pullup_control_bit[gi]),
				.own      (own_i),
				.pout     (pout_i),
				.poe      (poe_i),
				.pin_out  (pin_out[gi]),
				.pin_oe_n (pin_oe_n[gi]),
				.pin_pu   (pin_pu[gi])
			);
		end
	endgenerate

	// Strobe pins: address_strobe_n, write, read
	always @(posedge aclk) begin
		if (!aresetn) begin
			strobe_out  <= 3'h7;
			strobe_oe_n <= 3'h7;
		end else if (!expanded) begin
			// Single-chip: strobes unused, left floating
			strobe_out  <= 3'h7;
			strobe_oe_n <= 3'h7;
		end else begin
			case (st)
				ST_NORMAL: begin
					strobe_out  <= {bus_as_n, bus_wr_n, bus_rd_n};
					strobe_oe_n <= 3'h0;
				end
				ST_HWSTBY: begin
					strobe_out  <= 3'h7;
					strobe_oe_n <= 3'h7;
				end
				// Reset, software standby and sleep park high
				default: begin
					strobe_out  <= 3'h7;
					strobe_oe_n <= 3'h0;
				end
			endcase
		end
	end

	// System clock pin
	always @(posedge aclk) begin
		if (!aresetn) begin
			clk_pin_out  <= 1'b1;
			clk_pin_oe_n <= 1'b1;
		end else begin
			case (st)
				// Running: expanded always, single-chip by direction
				ST_NORMAL, ST_SLEEP: begin
					clk_pin_out  <= clk_tgl;
					clk_pin_oe_n <= !(expanded || clk_dir);
				end
				// Clock stopped: hold high where driven
				ST_SWSTBY: begin
					clk_pin_out  <= 1'b1;
					clk_pin_oe_n <= !(expanded || clk_dir);
				end
				ST_RESET: begin
					clk_pin_out  <= clk_tgl;
					clk_pin_oe_n <= !expanded;
				end
				default: begin
					clk_pin_out  <= 1'b1;
					clk_pin_oe_n <= 1'b1;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== tb/psc_sup_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Board supervisor on the reset and standby pins
module psc_sup_model (
	input  wire  aclk,
	output logic reset_n_pin,
	output logic hw_standby_n_pin
);
	// Both pins idle high until a sequence runs
	initial begin
		reset_n_pin = 1'b1;
		hw_standby_n_pin = 1'b1;
	end

	// Standby entry; a short lead loses the RAM
	task automatic enter(input int lead);
		int i;
		for (i = 0; i < lead; i++) begin
			@(posedge aclk) reset_n_pin <= 1'b0;
		end
		@(posedge aclk) hw_standby_n_pin <= 1'b0;
		// Latest legal release: same edge as standby
		reset_n_pin <= 1'b1;
	endtask

	// Standby exit with a reset lead of given cycles
	task automatic leave(input int lead);
		int i;
		for (i = 0; i < lead; i++) begin
			@(posedge aclk) reset_n_pin <= 1'b0;
		end
		@(posedge aclk) hw_standby_n_pin <= 1'b1;
		repeat (2) @(posedge aclk);
		reset_n_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== tb/psc_port_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
// Watches pin states and bus answers at the top ports
module psc_port_ctrl_chk (
	input wire                 aclk,
	input wire                 aresetn,
	input wire                 awvalid,
	input wire                 awready,
	input wire                 wvalid,
	input wire                 wready,
	input wire [1:0]           bresp,
	input wire                 bvalid,
	input wire                 bready,
	input wire                 arvalid,
	input wire                 arready,
	input wire [31:0]          rdata,
	input wire                 rvalid,
	input wire                 rready,
	input wire                 reset_n_pin,
	input wire                 hw_standby_n_pin,
	input wire [`PSC_NPIN-1:0] pin_oe_n,
	input wire [2:0]           strobe_out,
	input wire [2:0]           strobe_oe_n,
	input wire                 clk_pin_oe_n,
	input wire                 ram_hold
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] lo_cnt; // Cycles with reset pin low, saturating

	// Count the reset lead the supervisor gave
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lo_cnt <= 8'h00;
		else if (reset_n_pin)
			lo_cnt <= 8'h00;
		else if (lo_cnt != 8'hff)
			lo_cnt <= lo_cnt + 8'h01;
	end

	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	sequence s_rd_ans;
		!rvalid && !arready ##1 rvalid;
	endsequence

	a_hw_float: assert property (
		!hw_standby_n_pin [*2] |=> &pin_oe_n && &strobe_oe_n && clk_pin_oe_n)
		else $error("pins driven in hardware standby");
	a_rst_strobes: assert property (
		(!reset_n_pin && hw_standby_n_pin) [*2]
		|=> strobe_oe_n == 3'h7 || strobe_out == 3'h7)
		else $error("strobe low during reset");
	a_ram_lead: assert property (
		$rose(ram_hold) |-> $past(lo_cnt) >= 8'h0a)
		else $error("ram hold set without reset lead");
	a_exit_drop: assert property (
		$rose(hw_standby_n_pin) && lo_cnt < 8'h0a |-> ##[1:3] !ram_hold)
		else $error("ram hold kept after short exit lead");
	a_wr_answer: assert property (
		s_wr_take |=> (!awready && !wready) ##1 bvalid)
		else $error("write answer late");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_rd_answer: assert property (s_rd_take |=> s_rd_ans)
		else $error("read answer timing");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
endmodule

bind psc_port_ctrl psc_port_ctrl_chk u_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready), .reset_n_pin(reset_n_pin),
	.hw_standby_n_pin(hw_standby_n_pin), .pin_oe_n(pin_oe_n),
	.strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
	.clk_pin_oe_n(clk_pin_oe_n), .ram_hold(ram_hold)
);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, ram_hold;
	logic        wake_req, bus_addr_valid, bus_as_n, bus_wr_n, bus_rd_n;
	logic        reset_n_pin, hw_standby_n_pin, clk_pin_out, clk_pin_oe_n;
	logic [7:0]  awaddr, araddr, bus_addr, periph_out, periph_oe, m_own, a;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, m_sys;
	logic [1:0]  bresp, rresp;
	logic [2:0]  strobe_out, strobe_oe_n;
	logic [15:0] pin_in, pin_out, pin_oe_n, pin_pu, m_dir, m_dat, m_pu, dir;
	logic [15:0] dat;
	logic        ck;
	int          mismatches, samples_checked, i, c;
	integer      seed;
	// RAM enable, entry lead and exit lead per standby case
	int          hw [5][3] = '{'{1, 10, 10}, '{1, 9, 10}, '{1, 0, 10},
		'{0, 10, 10}, '{1, 10, 0}};

	psc_port_ctrl dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.reset_n_pin(reset_n_pin), .hw_standby_n_pin(hw_standby_n_pin),
		.wake_req(wake_req), .bus_addr(bus_addr),
		.bus_addr_valid(bus_addr_valid), .bus_as_n(bus_as_n),
		.bus_wr_n(bus_wr_n), .bus_rd_n(bus_rd_n), .periph_out(periph_out),
		.periph_oe(periph_oe), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_pu(pin_pu), .strobe_out(strobe_out),
		.strobe_oe_n(strobe_oe_n), .clk_pin_out(clk_pin_out),
		.clk_pin_oe_n(clk_pin_oe_n), .ram_hold(ram_hold)
	);
	psc_sup_model sup (
		.aclk(aclk), .reset_n_pin(reset_n_pin),
		.hw_standby_n_pin(hw_standby_n_pin)
	);

	// Free running 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Verdict and end of run
	task automatic test_done;
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Compare one value; four-state so X matches only X
	task automatic chk(input string nm, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask

	// A wait that ran out ends the run
	task automatic hang;
		mismatches++;
		test_done();
	endtask

	// Expected register contents from the model
	function automatic logic [31:0] mrd(input logic [7:0] ad);
		case (ad)
		8'h00: return {28'h0, m_sys};
		8'h08: return {16'h0, m_dir};
		8'h0c: return {16'h0, m_dat};
		8'h10: return {16'h0, m_pu};
		8'h14: return {24'h0, m_own};
		default: return 32'h0;
		endcase
	endfunction

	// One bus write; model follows the mapped registers
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		int n;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'($random(seed)); // Sometimes late, to stall bvalid
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
			if (bvalid)
				bready <= 1'b1;
		end
		bready <= 1'b0;
		if (n == 40)
			hang();
		chk("bresp", bresp, {ad > 8'h18, 1'b0});
		case (ad)
		8'h00: m_sys = v[3:0];
		8'h08: m_dir = v[15:0];
		8'h0c: m_dat = v[15:0];
		8'h10: m_pu = v[15:0];
		8'h14: m_own = v[7:0];
		default: ;
		endcase
	endtask

	// One bus read; data taken at the answer edge
	task automatic rd(input logic [7:0] ad, output logic [31:0] v);
		int n;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'($random(seed)); // Sometimes late, to stall rvalid
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
			if (rvalid)
				rready <= 1'b1;
		end
		rready <= 1'b0;
		v = rdata;
		if (n == 40)
			hang();
		chk("rresp", rresp, {ad > 8'h18, 1'b0});
	endtask

	// Port pins against a direction and data pair
	task automatic pchk(input logic [15:0] dr, dt);
		chk("pin_oe_n", pin_oe_n, {~dr});
		chk("pin_out", pin_out & dr, dt & dr);
		chk("pin_pu", pin_pu, {~dr & m_pu});
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Wake from a low-power state and expect normal
	task automatic wake;
		wake_req <= 1'b1;
		tk(1);
		wake_req <= 1'b0;
		tk(3);
		rd(8'h18, d);
		chk("state", d[2:0], 3'h0);
	endtask

	initial begin
		seed = 32'h251f;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wake_req, bus_addr_valid} = 0;
		{bus_as_n, bus_wr_n, bus_rd_n} = 3'h7;
		wstrb = 4'hf;
		bus_addr = 8'h00;
		periph_out = 8'h00;
		periph_oe = 8'h00;
		pin_in = $random(seed);
		{m_dir, m_dat, m_pu, m_own, m_sys} = {56'h0, 4'h7};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		tk(2);
		// Reset values, a read-only status and unmapped places
		wr(8'h18, 32'hffffffff);
		wr(8'h20, $random(seed));
		for (i = 0; i <= 32; i += 4) begin
			rd(i[7:0], d);
			if (i != 24)
				chk("reg", d, mrd(i[7:0]));
		end
		rd(8'h18, d);
		chk("status", d & 32'h00ffff17, {8'h0, pin_in, 8'h0});
		// Sleep, software standby, and both bits at once
		wr(8'h00, 32'hf);
		for (c = 1; c <= 3; c++) begin
			wr(8'h08, $random(seed));
			wr(8'h0c, $random(seed));
			wr(8'h10, $random(seed));
			wr(8'h14, c[1] ? 32'hff : 32'h0);
			periph_out <= $random(seed);
			periph_oe <= $random(seed);
			dir = m_dir;
			dat = m_dat;
			wr(8'h04, c);
			tk(3);
			wr(8'h0c, $random(seed));
			tk(3);
			rd(8'h18, d);
			chk("state", d[2:0], c[1] ? 3'h2 : 3'h1);
			if (c[1]) begin
				m_own = 8'h00;
				pchk(m_dir, m_dat);
				rd(8'h14, d);
				chk("own", d, 32'h0);
				chk("clk_pin", {clk_pin_oe_n, clk_pin_out}, 2'h1);
			end else begin
				pchk(dir, dat);
				ck = clk_pin_out;
				tk(1);
				chk("clk_pin", {clk_pin_oe_n, clk_pin_out ^ ck}, 2'h1);
			end
			wake();
		end
		// Expanded mode: held address and idle strobes
		wr(8'h00, 32'hb);
		for (c = 1; c <= 2; c++) begin
			bus_addr <= $random(seed);
			bus_addr_valid <= 1'b1;
			{bus_as_n, bus_wr_n, bus_rd_n} <= $random(seed);
			tk(2);
			a = bus_addr;
			bus_addr_valid <= 1'b0;
			wr(8'h04, c);
			bus_addr <= ~a;
			bus_addr_valid <= 1'b1;
			tk(4);
			if (c == 1)
				chk("addr", {pin_oe_n[15:8], pin_out[15:8]}, {8'h0, a});
			chk("strobes", {strobe_oe_n, strobe_out}, 6'h07);
			bus_addr_valid <= 1'b0;
			wake();
		end
		// Hardware standby entry and exit cases
		for (c = 0; c < 5; c++) begin
			wr(8'h00, hw[c][0] ? 32'h7 : 32'h6);
			sup.enter(hw[c][1]);
			tk(3);
			chk("ram_hold", ram_hold, hw[c][0] && hw[c][1] >= 10);
			chk("float", {&pin_oe_n, &strobe_oe_n, clk_pin_oe_n}, 3'h7);
			sup.leave(hw[c][2]);
			tk(3);
			chk("ram_kept", ram_hold,
				hw[c][0] && hw[c][1] >= 10 && hw[c][2] >= 10);
			rd(8'h18, d);
			chk("exit_ok", d[5], hw[c][2] >= 10);
		end
		test_done();
	end
endmodule
`default_nettype wire
